/* File: hdl/ple_pkg.sv */
// Constants, encodings and register map of the privileged library mode
// entry and exit controller. Assumes a 34-bit program counter space.
package ple_pkg;

   // ==========================================================
   // Address widths
   localparam int PC_W = 34;
   localparam int OFS_W = 14;
   localparam int BASE_W = PC_W - OFS_W;
   localparam int ADDR_W = 12;

   // ==========================================================
   // Events, lowest index has the highest priority
   localparam int EV_N = 9;
   localparam int EV_IW = 4;
   localparam logic [EV_IW-1:0] EV_RESET = 4'h0;
   localparam logic [EV_IW-1:0] EV_MACHINE_CHECK_ENTRY = 4'h1;
   localparam logic [EV_IW-1:0] EV_ARITHMETIC_TRAP_ENTRY = 4'h2;
   localparam logic [EV_IW-1:0] EV_INTR = 4'h3;
   localparam logic [EV_IW-1:0] EV_DERR = 4'h4;
   localparam logic [EV_IW-1:0] EV_DTBM = 4'h5;
   localparam logic [EV_IW-1:0] EV_ITBM = 4'h6;
   localparam logic [EV_IW-1:0] EV_CALL = 4'h7;
   localparam logic [EV_IW-1:0] EV_RESERVED_OPCODE_ENTRY = 4'h8;
   localparam logic [EV_N-1:0] EV_RESET_MASK = 9'h001;

   // Entry offsets, indexed by event
   localparam logic [OFS_W-1:0] ENTRY_OFS [0:EV_N-1] = '{
      14'h0000, 14'h0020, 14'h0060, 14'h00e0, 14'h01e0,
      14'h09e0, 14'h03e0, 14'h2000, 14'h13e0};
   localparam logic [OFS_W-1:0] CALL_OFS_BASE = 14'h2000;
   localparam int CALL_FN_HI = 7;
   localparam int CALL_FN_LO_W = 6;
   localparam int CALL_OFS_SHIFT = 6;
   localparam logic [PC_W-1:0] CALL_PC_STEP = 34'h000000004;

   // ==========================================================
   // Instruction kinds presented by the decoder
   localparam logic [2:0] INSTR_NORMAL = 3'h0;
   localparam logic [2:0] INSTR_RD_IREG = 3'h1;
   localparam logic [2:0] INSTR_WR_IREG = 3'h2;
   localparam logic [2:0] INSTR_PHYS_LD = 3'h3;
   localparam logic [2:0] INSTR_PHYS_ST = 3'h4;
   localparam logic [2:0] INSTR_RETURN = 3'h5;
   localparam logic [2:0] INSTR_CALL = 3'h6;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [ADDR_W-1:0] REG_LIB_BASE = 12'h000;
   localparam logic [ADDR_W-1:0] REG_EXC_LO = 12'h004;
   localparam logic [ADDR_W-1:0] REG_EXC_HI = 12'h008;
   localparam logic [ADDR_W-1:0] REG_STATUS = 12'h00c;
   localparam int EXC_HI_W = PC_W - 32;
   localparam logic [BASE_W-1:0] LIB_BASE_RST = 20'h00000;
   localparam logic [PC_W-1:0] EXCEPTION_ADDRESS_REGISTER_RST = 34'h000000000;
   // Status fields
   localparam int ST_MODE = 0;
   localparam int ST_INTR_EN = 1;
   localparam int ST_IMAP_EN = 2;
   localparam int ST_BUSY = 3;
   localparam int ST_CAUSE_LO = 4;
   localparam int ST_PEND_LO = 8;

   // ==========================================================
   // Controller states
   typedef enum logic [2:0] {
      S_RUN = 3'b001,
      S_DRAIN = 3'b010,
      S_DISP = 3'b100
   } ple_state_type;

endpackage : ple_pkg

/* File: hdl/ple_sync2.sv */
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input is a slow level, not a pulse.
`timescale 1ns/10ps
`default_nettype none
module ple_sync2 (
   input wire logic clk_i, // Core clock
   input wire logic rst_i, // Asynchronous reset, active high
   input wire logic d_i, // Asynchronous level
   output logic q_o // Synchronised level
);
   logic meta_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         q_o <= 1'b0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : ple_sync2
`default_nettype wire

/* File: hdl/ple_prio.sv */
// Fixed priority picker: the lowest set request index wins.
// Assumes IW is wide enough to hold N-1.
`timescale 1ns/10ps
`default_nettype none
module ple_prio #(
   parameter int N = 9,
   parameter int IW = 4
) (
   input wire logic [N-1:0] req_i, // Request vector
   output logic any_o, // At least one request
   output logic [IW-1:0] idx_o // Index of the winner
);
   always_comb begin
      any_o = 1'b0;
      idx_o = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req_i[i]) begin
            any_o = 1'b1;
            idx_o = IW'(i);
         end
      end
   end
endmodule : ple_prio
`default_nettype wire

/* File: hdl/ple_ctrl.sv */
// Privileged library mode entry and exit controller with APB registers.
// Assumes event inputs are one-cycle pulses from core logic on clk_i,
// the pipeline answers a drain request with drain_done_i, and irq_i is
// an asynchronous pin level.
//
// Contract
// - Every library entry first drains the instruction pipeline.
// - After drain, save PC, dispatch, and enter privileged library mode.
// - Entry address is an offset added to the programmable library base.
// - In library mode, instruction mapping off, data mapping stays on.
// - No interrupts are taken while in privileged library mode.
// - Internal register access, physical load/store and return run in mode.
// - Mode-only instruction outside the mode dispatches to reserved opcode entry.
// - Return jumps to the address held in the exception address register.
// - Return with bit 0 clear enables interrupts, mapping, leaves the mode.
// - Reset enters the mode at the reset routine until a clean return.
// - Hardware errors dispatch to routines chosen by the error type.
// - A sensed interrupt dispatches to the interrupt routine.
// - Data and instruction translation misses dispatch to separate routines.
// - Dispatch bits 13:0 from offset, bits 33:14 from library base.
// - Library base register is zero after reset.
// - Simultaneous events resolve by fixed priority: reset, check, arithmetic_trap_entry, interrupt.
// - Library call instruction saves PC plus 4 as the return address.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ple_ctrl
   import ple_pkg::*;
(
   input wire logic clk_i, // Core clock, 250 MHz
   input wire logic rst_i, // Asynchronous reset, active high
   // APB slave
   input wire logic psel_i, // Slave select
   input wire logic penable_i, // Access phase
   input wire logic pwrite_i, // Write when high
   input wire logic [ADDR_W-1:0] paddr_i, // Byte address
   input wire logic [31:0] pwdata_i, // Write data
   output logic [31:0] prdata_o, // Read data
   output logic pready_o, // Transfer done
   output logic pslverr_o, // Unmapped address
   // Events from core logic
   input wire logic machine_check_entry_i, // Uncorrected hardware error
   input wire logic arithmetic_trap_entry_i, // Arithmetic exception
   input wire logic derr_i, // Data fetch error
   input wire logic dtb_miss_i, // Data translation miss
   input wire logic itb_miss_i, // Instruction translation miss
   input wire logic irq_i, // Interrupt pin level
   // Decoded instruction
   input wire logic instr_valid_i, // Instruction issued
   input wire logic [2:0] instr_kind_i, // Instruction kind
   input wire logic [7:0] call_func_i, // Library call function
   input wire logic [PC_W-1:0] cur_pc_i, // PC of the oldest instruction
   // Pipeline
   output logic drain_req_o, // Drain the pipeline
   input wire logic drain_done_i, // Pipeline empty
   output logic redirect_o, // One-cycle fetch redirect
   output logic [PC_W-1:0] redirect_pc_o, // New fetch PC
   output logic priv_exec_o, // Mode-only instruction executes
   output logic priv_mode_o, // Privileged library mode
   output logic imap_en_o, // Instruction stream mapping on
   output logic dmap_en_o, // Data stream mapping on
   output logic intr_en_o // Interrupts enabled
);

   // ==========================================================
   // Signals
   ple_state_type state_q;
   ple_state_type state_d;
   logic [EV_N-1:0] pend_q;
   logic [EV_N-1:0] ev_set;
   logic [EV_N-1:0] ev_clr;
   logic [EV_N-1:0] req;
   logic [BASE_W-1:0] lib_base_q;
   logic [PC_W-1:0] exception_address_register_q;
   logic [7:0] call_func_q;
   logic [EV_IW-1:0] cause_q;
   logic [EV_IW-1:0] win_idx;
   logic win_any;
   logic irq_s;
   logic mode_only;
   logic is_ret;
   logic ret_go;
   logic disp_go;
   logic [OFS_W-1:0] disp_ofs;
   logic [PC_W-1:0] save_pc;
   logic apb_acc;
   logic apb_wr;
   logic apb_hit;
   logic [31:0] rd_mux;

   ple_sync2 u_irq_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(irq_i),
      .q_o(irq_s)
   );

   // ==========================================================
   // Event collection
   assign mode_only = (instr_kind_i == INSTR_RD_IREG) || (instr_kind_i == INSTR_WR_IREG)
      || (instr_kind_i == INSTR_PHYS_LD) || (instr_kind_i == INSTR_PHYS_ST)
      || (instr_kind_i == INSTR_RETURN);
   assign is_ret = instr_valid_i && (instr_kind_i == INSTR_RETURN) && priv_mode_o;

   always_comb begin
      ev_set = '0;
      ev_set[EV_MACHINE_CHECK_ENTRY] = machine_check_entry_i;
      ev_set[EV_ARITHMETIC_TRAP_ENTRY] = arithmetic_trap_entry_i;
      ev_set[EV_DERR] = derr_i;
      ev_set[EV_DTBM] = dtb_miss_i;
      ev_set[EV_ITBM] = itb_miss_i;
      if (instr_valid_i && state_q == S_RUN) begin
         ev_set[EV_CALL] = (instr_kind_i == INSTR_CALL);
         ev_set[EV_RESERVED_OPCODE_ENTRY] = mode_only && !priv_mode_o;
      end
   end

   // Interrupt is a level, never latched, and masked in library mode
   always_comb begin
      req = pend_q;
      req[EV_INTR] = irq_s && intr_en_o;
   end

   ple_prio #(
      .N(EV_N),
      .IW(EV_IW)
   ) u_prio (
      .req_i(req),
      .any_o(win_any),
      .idx_o(win_idx)
   );

   // ==========================================================
   // Sequencing
   assign disp_go = (state_q == S_DRAIN) && drain_done_i && win_any;
   // Pending events pre-empt a return in the same cycle
   assign ret_go = is_ret && (state_q == S_RUN) && !win_any;

   always_comb begin
      state_d = state_q;
      case (state_q)
         S_RUN: begin
            if (win_any) begin
               state_d = S_DRAIN;
            end
         end
         S_DRAIN: begin
            if (drain_done_i) begin
               state_d = win_any ? S_DISP : S_RUN;
            end
         end
         S_DISP: begin
            state_d = S_RUN;
         end
         default: begin
            state_d = S_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= S_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         drain_req_o <= 1'b0;
      end else begin
         drain_req_o <= (state_d == S_DRAIN);
      end
   end

   // Set wins over the clear of the dispatched event
   always_comb begin
      ev_clr = '0;
      if (disp_go) begin
         ev_clr[win_idx] = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_q <= EV_RESET_MASK;
      end else begin
         pend_q <= (pend_q & ~ev_clr) | ev_set;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         call_func_q <= 8'h00;
      end else if (ev_set[EV_CALL]) begin
         call_func_q <= call_func_i;
      end
   end

   // ==========================================================
   // Dispatch address
   always_comb begin
      disp_ofs = ENTRY_OFS[win_idx];
      if (win_idx == EV_CALL) begin
         disp_ofs = CALL_OFS_BASE | OFS_W'({call_func_q[CALL_FN_HI],
            call_func_q[CALL_FN_LO_W-1:0]} << CALL_OFS_SHIFT);
      end
   end

   always_comb begin
      save_pc = cur_pc_i;
      if (win_idx == EV_CALL) begin
         save_pc = cur_pc_i + CALL_PC_STEP;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         redirect_o <= 1'b0;
         redirect_pc_o <= EXCEPTION_ADDRESS_REGISTER_RST;
      end else begin
         redirect_o <= disp_go || ret_go;
         if (disp_go) begin
            redirect_pc_o <= {lib_base_q, disp_ofs};
         end else if (ret_go) begin
            redirect_pc_o <= {exception_address_register_q[PC_W-1:1], 1'b0};
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cause_q <= EV_RESET;
      end else if (disp_go) begin
         cause_q <= win_idx;
      end
   end

   // ==========================================================
   // Mode flags
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         priv_mode_o <= 1'b1;
         imap_en_o <= 1'b0;
         intr_en_o <= 1'b0;
      end else if (disp_go) begin
         priv_mode_o <= 1'b1;
         imap_en_o <= 1'b0;
         intr_en_o <= 1'b0;
      end else if (ret_go && !exception_address_register_q[0]) begin
         priv_mode_o <= 1'b0;
         imap_en_o <= 1'b1;
         intr_en_o <= 1'b1;
      end
   end

   // Data stream translation is never turned off by this block
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dmap_en_o <= 1'b1;
      end else begin
         dmap_en_o <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         priv_exec_o <= 1'b0;
      end else begin
         priv_exec_o <= instr_valid_i && mode_only && priv_mode_o
            && (state_q == S_RUN) && !win_any;
      end
   end

   // ==========================================================
   // APB slave, one wait state so every answer comes from a flop
   assign apb_acc = psel_i && penable_i && !pready_o;
   // Writes land only at the completion edge, where the master sees pready high
   assign apb_wr = psel_i && penable_i && pready_o && pwrite_i;
   assign apb_hit = (paddr_i == REG_LIB_BASE) || (paddr_i == REG_EXC_LO)
      || (paddr_i == REG_EXC_HI) || (paddr_i == REG_STATUS);

   always_comb begin
      rd_mux = 32'h00000000;
      case (paddr_i)
         REG_LIB_BASE: rd_mux[BASE_W-1:0] = lib_base_q;
         REG_EXC_LO: rd_mux = exception_address_register_q[31:0];
         REG_EXC_HI: rd_mux[EXC_HI_W-1:0] = exception_address_register_q[PC_W-1:32];
         REG_STATUS: begin
            rd_mux[ST_MODE] = priv_mode_o;
            rd_mux[ST_INTR_EN] = intr_en_o;
            rd_mux[ST_IMAP_EN] = imap_en_o;
            rd_mux[ST_BUSY] = (state_q != S_RUN);
            rd_mux[ST_CAUSE_LO +: EV_IW] = cause_q;
            rd_mux[ST_PEND_LO +: EV_N] = pend_q;
         end
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h00000000;
      end else begin
         pready_o <= apb_acc;
         pslverr_o <= apb_acc && !apb_hit;
         prdata_o <= (apb_acc && !pwrite_i) ? rd_mux : 32'h00000000;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lib_base_q <= LIB_BASE_RST;
      end else if (apb_wr && paddr_i == REG_LIB_BASE) begin
         lib_base_q <= pwdata_i[BASE_W-1:0];
      end
   end

   // Hardware save on dispatch beats a software write in the same cycle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         exception_address_register_q <= EXCEPTION_ADDRESS_REGISTER_RST;
      end else if (disp_go) begin
         exception_address_register_q <= save_pc;
      end else if (apb_wr && paddr_i == REG_EXC_LO) begin
         exception_address_register_q[31:0] <= pwdata_i;
      end else if (apb_wr && paddr_i == REG_EXC_HI) begin
         exception_address_register_q[PC_W-1:32] <= pwdata_i[EXC_HI_W-1:0];
      end
   end

endmodule : ple_ctrl
`default_nettype wire

/* File: verification/ple_checker.sv */
// Checker: timing properties at the controller ports.
// Assumes no event overlaps a return or a mode-only issue.
`timescale 1ns/10ps
`default_nettype none
module ple_checker
   import ple_pkg::*;
(
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic psel_i, // Select
   input wire logic penable_i, // Access
   input wire logic pwrite_i, // Write
   input wire logic [ADDR_W-1:0] paddr_i, // Address
   input wire logic [31:0] pwdata_i, // Data
   input wire logic pready_o, // Ready
   input wire logic machine_check_entry_i, // Event
   input wire logic arithmetic_trap_entry_i, // Event
   input wire logic derr_i, // Event
   input wire logic dtb_miss_i, // Event
   input wire logic itb_miss_i, // Event
   input wire logic instr_valid_i, // Issue
   input wire logic [2:0] instr_kind_i, // Kind
   input wire logic drain_req_o, // Drain
   input wire logic drain_done_i, // Empty
   input wire logic redirect_o, // Redirect
   input wire logic [PC_W-1:0] redirect_pc_o, // Target
   input wire logic priv_exec_o, // Executed
   input wire logic priv_mode_o, // Mode
   input wire logic imap_en_o, // I map
   input wire logic dmap_en_o, // D map
   input wire logic intr_en_o // Interrupts
);
   // ==========================================================
   // Helpers
   logic ev, ret, calm, quiet, ev_q, ev2_q;
   logic [BASE_W-1:0] base_q;
   assign ev = machine_check_entry_i | arithmetic_trap_entry_i | derr_i | dtb_miss_i | itb_miss_i;
   assign ret = instr_valid_i && (instr_kind_i == INSTR_RETURN);
   // An event still on its way to the drain state would win over an issue
   assign calm = !drain_req_o && !redirect_o && !ev && !ev_q && !ev2_q;
   assign quiet = calm && priv_mode_o;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ev_q <= 1'b0;
         ev2_q <= 1'b0;
      end else begin
         ev_q <= ev;
         ev2_q <= ev_q;
      end
   end
   // Shadow base, written at the completion edge, where pready is high
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         base_q <= LIB_BASE_RST;
      end else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == REG_LIB_BASE) begin
         base_q <= pwdata_i[BASE_W-1:0];
      end
   end
   // ==========================================================
   // Properties
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_DRAIN: assert property (redirect_o && !$past(ret) |-> $past(drain_req_o) && $past(drain_done_i))
      else $error("dispatch before the pipeline drained");
   AST_ENTER: assert property (redirect_o && !$past(ret) |-> priv_mode_o && !intr_en_o)
      else $error("dispatch did not enter library mode");
   AST_MAP: assert property (dmap_en_o && (imap_en_o == !priv_mode_o))
      else $error("mapping enables wrong for the mode");
   AST_BASE: assert property (redirect_o && !$past(ret) |-> redirect_pc_o[PC_W-1:OFS_W] == base_q)
      else $error("dispatch high bits differ from base");
   AST_RET: assert property (ret && quiet |=> redirect_o && priv_exec_o && !redirect_pc_o[0]
      && (intr_en_o != priv_mode_o))
      else $error("return misbehaved");
   AST_EXEC: assert property (instr_valid_i && instr_kind_i inside {[INSTR_RD_IREG:INSTR_PHYS_ST]}
      && quiet |=> priv_exec_o)
      else $error("mode-only instruction not executed");
   AST_REFUSE: assert property (instr_valid_i && instr_kind_i inside {[INSTR_RD_IREG:INSTR_RETURN]}
      && !priv_mode_o && calm |=> !priv_exec_o ##[0:60]
      (redirect_o && redirect_pc_o[OFS_W-1:0] == 14'h13e0))
      else $error("mode-only instruction not refused");
   AST_RESET: assert property ($past(rst_i) |-> priv_mode_o && !intr_en_o && redirect_pc_o == '0)
      else $error("reset did not leave library mode set");
endmodule : ple_checker

bind ple_ctrl ple_checker ple_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .pready_o(pready_o), .machine_check_entry_i(machine_check_entry_i), .arithmetic_trap_entry_i(arithmetic_trap_entry_i), .derr_i(derr_i),
   .dtb_miss_i(dtb_miss_i), .itb_miss_i(itb_miss_i), .instr_valid_i(instr_valid_i),
   .instr_kind_i(instr_kind_i), .drain_req_o(drain_req_o), .drain_done_i(drain_done_i),
   .redirect_o(redirect_o), .redirect_pc_o(redirect_pc_o), .priv_exec_o(priv_exec_o),
   .priv_mode_o(priv_mode_o), .imap_en_o(imap_en_o), .dmap_en_o(dmap_en_o),
   .intr_en_o(intr_en_o));
`default_nettype wire

/* File: verification/ple_pipe_model.sv */
// Pipeline model: reports empty a set number of cycles into a drain.
// Assumes the drain request is held until the dispatch.
`timescale 1ns/10ps
`default_nettype none
module ple_pipe_model (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic drain_req_i, // Drain request
   input wire logic [3:0] lat_i, // Cycles to empty
   output logic drain_done_o // Pipeline empty
);
   // ==========================================================
   // Drain timer; a running pipeline never claims to be empty
   logic [3:0] cnt_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 4'h0;
      end else if (!drain_req_i) begin
         cnt_q <= 4'h0;
      end else if (cnt_q != 4'hf) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
   assign drain_done_o = drain_req_i && (cnt_q >= lat_i);
endmodule : ple_pipe_model
`default_nettype wire

/* File: verification/tb.sv */
// Testbench: events, instructions and APB traffic into the controller.
// Assumes the pipeline model answers every drain request.
`timescale 1ns/10ps
`default_nettype none
module tb
   import ple_pkg::*;
();
   // ==========================================================
   // Signals
   logic clk_i, rst_i, psel, pen, pwr, pready, perr, irq, iv, redir, pexec;
   logic pmode, imap, dmap, ien, drq, ddone;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, r, seed;
   logic [4:0] ev;
   logic [2:0] kind;
   logic [7:0] func;
   logic [33:0] pc, rpc, epc;
   logic [19:0] base;
   logic [3:0] lat;
   logic err;
   int miscompares, n_tests, i, n;
   logic [13:0] ofs_t [5] = '{14'h0020, 14'h0060, 14'h01e0, 14'h09e0, 14'h03e0};
   ple_ctrl ple_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(perr), .machine_check_entry_i(ev[4]), .arithmetic_trap_entry_i(ev[3]), .derr_i(ev[2]),
      .dtb_miss_i(ev[1]), .itb_miss_i(ev[0]), .irq_i(irq), .instr_valid_i(iv),
      .instr_kind_i(kind), .call_func_i(func), .cur_pc_i(pc), .drain_req_o(drq),
      .drain_done_i(ddone), .redirect_o(redir), .redirect_pc_o(rpc), .priv_exec_o(pexec),
      .priv_mode_o(pmode), .imap_en_o(imap), .dmap_en_o(dmap), .intr_en_o(ien));
   ple_pipe_model ple_pipe_model_inst (.clk_i(clk_i), .rst_i(rst_i), .drain_req_i(drq),
      .lat_i(lat), .drain_done_o(ddone));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // ==========================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic [33:0] ent(input logic [13:0] o);
      return {base, o};
   endfunction : ent
   task automatic chk(input string s, input logic [33:0] e, input logic [33:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      pen <= 1'b1;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      chk("pready", 34'h1, 34'(pready));
   endtask : apb
   task automatic ins(input logic [2:0] k, input logic [7:0] f);
      @(posedge clk_i);
      iv <= 1'b1;
      kind <= k;
      func <= f;
      @(posedge clk_i);
      iv <= 1'b0;
   endtask : ins
   task automatic pulse(input logic [4:0] v);
      @(posedge clk_i);
      ev <= v;
      @(posedge clk_i);
      ev <= 5'h00;
   endtask : pulse
   task automatic disp(input logic [33:0] e, input logic [2:0] m);
      int k;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (redir !== 1'b1 && k < 200);
      chk("redirect", 34'h1, 34'(redir));
      chk("target", e, rpc);
      chk("mode", 34'(m), 34'({pmode, imap, ien}));
   endtask : disp
   task automatic native();
      r = rnd();
      apb(1'b1, REG_EXC_HI, 32'h0);
      apb(1'b1, REG_EXC_LO, {r[31:1], 1'b0});
      ins(INSTR_RETURN, 8'h00);
      disp({2'b00, r[31:1], 1'b0}, 3'b011);
   endtask : native
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict
   // ==========================================================
   // Scenarios
   initial begin
      seed = 32'hd6f4;
      {psel, pen, pwr, irq, iv} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      ev = 5'h00;
      kind = INSTR_NORMAL;
      func = 8'h00;
      pc = '0;
      lat = 4'h0;
      base = 20'h00000;
      miscompares = 0;
      n_tests = 0;
      rst_i = 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      disp(34'h0, 3'b100);
      apb(1'b0, REG_STATUS, 32'h0);
      chk("status", 34'(32'h1 << ST_MODE), 34'(rd));
      apb(1'b0, REG_LIB_BASE, 32'h0);
      chk("base", 34'h0, 34'(rd));
      apb(1'b0, 12'hffc, 32'h0);
      chk("slverr", 34'h1, 34'(err));
      chk("unmapped data", 34'h0, 34'(rd));
      r = rnd();
      base = r[19:0];
      apb(1'b1, REG_LIB_BASE, 32'(base));
      for (i = 0; i < 5; i++) begin
         r = rnd();
         lat <= r[3:0];
         epc = {r[5:4], rnd()};
         // Even passes keep the mode, odd ones leave it; the loop ends in mode
         epc[0] = ~i[0];
         pc <= epc;
         pulse(5'h10 >> i);
         disp(ent(ofs_t[i]), 3'b100);
         apb(1'b0, REG_EXC_LO, 32'h0);
         chk("saved pc", 34'(epc[31:0]), 34'(rd));
         ins(INSTR_RETURN, 8'h00);
         disp({epc[33:1], 1'b0}, epc[0] ? 3'b100 : 3'b011);
      end
      native();
      irq <= 1'b1;
      pulse(5'h18);
      disp(ent(14'h0020), 3'b100);
      disp(ent(14'h0060), 3'b100);
      n = 0;
      repeat (40) begin
         @(posedge clk_i);
         n = n + int'(redir === 1'b1);
      end
      chk("redirects in mode", 34'h0, 34'(n));
      native();
      disp(ent(14'h00e0), 3'b100);
      irq <= 1'b0;
      native();
      r = rnd();
      epc = {r[9:8], rnd()};
      pc <= epc;
      ins(INSTR_CALL, r[7:0]);
      disp(ent(14'h2000 | {r[7], r[5:0], 6'h00}), 3'b100);
      apb(1'b0, REG_EXC_LO, 32'h0);
      epc = epc + 34'h4;
      chk("call pc", 34'(epc[31:0]), 34'(rd));
      for (i = 1; i < 5; i++) begin
         ins(3'(i), 8'h00);
         @(posedge clk_i);
         chk("exec", 34'h1, 34'(pexec));
      end
      for (i = 1; i < 6; i++) begin
         native();
         ins(3'(i), 8'h00);
         disp(ent(14'h13e0), 3'b100);
      end
      print_verdict();
   end
   initial begin
      #200000;
      miscompares++;
      print_verdict();
   end
endmodule : tb
`default_nettype wire
